// ==== rtl/mcs_regs.svh ====
// Purpose: register offsets, fields, reset values of the memory cycle sequencer
// Assumes: 32-bit Avalon-MM slave, byte addresses
// Notes: definitions only
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define MCS_OFF_CTRL 5'h00
`define MCS_OFF_CONFIG 5'h04
`define MCS_OFF_ADDR 5'h08
`define MCS_OFF_WDATA 5'h0c
`define MCS_OFF_RDATA 5'h10
`define MCS_OFF_STATUS 5'h14

// ----------------------------------------
// fields
// ----------------------------------------
`define MCS_CTRL_START 0
`define MCS_CTRL_WRITE 1
`define MCS_CTRL_CODE_LSB 2
`define MCS_CFG_WAIT_LSB 0
`define MCS_CFG_SYNC_BUS 2
`define MCS_CFG_LATCHED_RETRY 3
`define MCS_CFG_RETRY_SYNC 4
`define MCS_STAT_BUSY 0
`define MCS_STAT_DONE 1
`define MCS_STAT_RETRY 2
`define MCS_STAT_MODE 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define MCS_CODE_IDLE 3'h7
`define MCS_RST_WAIT 2'h0
`define MCS_RST_SYNC_BUS 1'h1
`define MCS_RST_RETRY_SYNC 1'h1

`endif

// ==== rtl/mcs_pkg.sv ====
// Purpose: types of the memory cycle sequencer
// Assumes: nothing
// Notes: one struct holds all state
package mcs_pkg;

  typedef enum logic [2:0] {
    st_idle, st_request, st_first, st_wait, st_second, st_release, st_holdoff, st_retry_wait
  } seq_state_type;

  typedef struct packed {
    seq_state_type st;
    logic ph;
    logic [1:0] wcnt;
    logic first_wait;
    logic fin;
    logic term;
    logic retry_seen;
    logic mode;
    logic mode_taken;
    logic [1:0] wait_cfg;
    logic sync_bus;
    logic latched_retry_enable;
    logic retry_sync;
    logic wr;
    logic [2:0] code;
    logic [30:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic busy;
    logic done;
    logic retry_status;
    logic bus_req;
    logic gack_out;
    logic gack_oe_n;
    logic ecs_n;
    logic adstb_n;
    logic ds_n;
    logic data_oe_n;
    logic [2:0] pin_code;
    logic dir;
    logic [1:0] ack_s1;
    logic [1:0] ack_s2;
    logic brt_s1;
    logic brt_s2;
    logic wait_q;
    logic [31:0] readdata;
  } seq_regs_type;

endpackage : mcs_pkg

// ==== rtl/master_memory_cycle_sequencer.sv ====
// Purpose: bus-master memory cycle sequencer with Avalon-MM register port
// Assumes: each bus state takes two clk cycles, ph 0 = rising half, ph 1 = falling half
// Notes: all outputs registered; single clock
//
// Summary of operation
// R1 - address, status code, direction driven at cycle start, held to cycle end
// R2 - big-endian: early strobe at first-state rise, address strobe at its fall
// R3 - big-endian sync: size acknowledges sampled each second-state rise until low
// R4 - big-endian sync read: data strobe at first fall, data caught final fall
// R5 - big-endian sync write: data at first fall, data strobe only with waits
// R6 - big-endian: address and data strobes dropped at final second-state fall
// R7 - big-endian async: acknowledges synchronised, sampled at first and second falls
// R8 - big-endian async: sync termination sampled at second-state rise
// R9 - big-endian async: end 1.5 clocks after acknowledge, 1 after termination
// R10 - big-endian async write: data strobe at first wait fall; reads at first fall
// R11 - memory keeps terminations off early unless a two-clock cycle is wanted
// R12 - little-endian: address-valid and early strobe at first rise, dropped later
// R13 - little-endian sync: ready sampled at end of each second state
// R14 - little-endian sync: read data caught at final end; write data held
// R15 - little-endian async: ready sampled on falls, end 1.5 clocks later
// R16 - little-endian async read: data strobe from first rise to final fall
// R17 - little-endian async write: data strobe at first wait rise, none zero-wait
// R18 - retry ends cycle at second state end and releases the bus
// R19 - without latch re-request; with latch wait for status clear and retry off
// R20 - retry wins over acknowledge, termination and ready
// R21 - config bit selects sync retry sampling or double-synchronised sampling
// R22 - system holds retry through hold-off and drops acknowledges after retry
// R23 - grant acknowledge driven high half a bus clock before release
// R24 - wait count inserts 0 to 3 wait states; terminations ignored meanwhile except async acknowledge at last wait fall
// R25 - config bit selects sync or async master termination
// R26 - strapped mode pin picks little-endian low, big-endian high
`timescale 1ns/1ps
`default_nettype none
`include "mcs_regs.svh"

module master_memory_cycle_sequencer (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic byte_order_pin_mode,
  output logic bus_request,
  input wire logic bus_grant,
  output logic grant_acknowledge_out,
  output logic grant_acknowledge_oe_n,
  output logic [30:0] mem_address,
  output logic [2:0] bus_status_code,
  output logic direction_strobe,
  output logic early_cycle_strobe_n,
  output logic address_strobe_n,
  output logic data_strobe_n,
  output logic [31:0] data_out,
  output logic data_oe_n,
  input wire logic [31:0] data_in,
  input wire logic [1:0] size_acknowledge_pair_n,
  input wire logic sync_termination_n,
  input wire logic bus_retry_request_n
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  mcs_pkg::seq_regs_type s_q;
  mcs_pkg::seq_regs_type s_d;
  logic ready_input_n;
  logic async_term;
  logic async_sample;
  logic retry_async_now;
  logic [31:0] addr_merged;

  assign ready_input_n = size_acknowledge_pair_n[0];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    addr_merged = merge_bytes({s_q.addr, 1'b0}, writedata, byteenable);
    // R7 synchronise async inputs
    s_d.ack_s1 = size_acknowledge_pair_n;
    s_d.ack_s2 = s_q.ack_s1;
    s_d.brt_s1 = bus_retry_request_n;
    s_d.brt_s2 = s_q.brt_s1;
    // big-endian needs both acknowledges, little-endian the ready line
    async_term = s_q.mode ? (s_q.ack_s2 == 2'h0) : !s_q.ack_s2[0];
    async_sample = 1'b0;
    retry_async_now = !s_q.retry_sync && !s_q.brt_s2;

    // R26 strap caught after reset
    if (!s_q.mode_taken) begin
      s_d.mode = byte_order_pin_mode;
      s_d.mode_taken = 1'b1;
    end

    // bus slave
    s_d.wait_q = 1'b1;
    if ((read || write) && s_q.wait_q) begin
      s_d.wait_q = 1'b0;
      case (address)
        `MCS_OFF_CTRL: s_d.readdata = {27'h0, s_q.code, s_q.wr, 1'b0};
        `MCS_OFF_CONFIG: s_d.readdata = {27'h0, s_q.retry_sync, s_q.latched_retry_enable, s_q.sync_bus, s_q.wait_cfg};
        `MCS_OFF_ADDR: s_d.readdata = {s_q.addr, 1'b0};
        `MCS_OFF_WDATA: s_d.readdata = s_q.wdata;
        `MCS_OFF_RDATA: s_d.readdata = s_q.rdata;
        `MCS_OFF_STATUS: s_d.readdata = {28'h0, s_d.mode, s_q.retry_status, s_q.done, s_q.busy};
        default: s_d.readdata = 32'h0;
      endcase
    end
    if (write && !s_q.wait_q) begin
      case (address)
        `MCS_OFF_CTRL: begin
          if (byteenable[0] && writedata[`MCS_CTRL_START] && s_q.st == mcs_pkg::st_idle) begin
            s_d.wr = writedata[`MCS_CTRL_WRITE];
            s_d.code = writedata[`MCS_CTRL_CODE_LSB +: 3];
            s_d.busy = 1'b1;
            s_d.bus_req = 1'b1;
            s_d.st = mcs_pkg::st_request;
          end
        end
        `MCS_OFF_CONFIG: begin
          if (byteenable[0] && !s_q.busy) begin
            // R24 wait count
            s_d.wait_cfg = writedata[`MCS_CFG_WAIT_LSB +: 2];
            // R25 termination mode
            s_d.sync_bus = writedata[`MCS_CFG_SYNC_BUS];
            s_d.latched_retry_enable = writedata[`MCS_CFG_LATCHED_RETRY];
            // R21 retry sampling select
            s_d.retry_sync = writedata[`MCS_CFG_RETRY_SYNC];
          end
        end
        `MCS_OFF_ADDR: begin
          if (!s_q.busy) begin
            s_d.addr = addr_merged[31:1];
          end
        end
        `MCS_OFF_WDATA: begin
          if (!s_q.busy) begin
            s_d.wdata = merge_bytes(s_q.wdata, writedata, byteenable);
          end
        end
        `MCS_OFF_STATUS: begin
          if (byteenable[0]) begin
            if (writedata[`MCS_STAT_DONE]) begin
              s_d.done = 1'b0;
            end
            if (writedata[`MCS_STAT_RETRY]) begin
              s_d.retry_status = 1'b0;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // cycle sequencer
    case (s_q.st)
      mcs_pkg::st_idle: begin
      end
      mcs_pkg::st_request: begin
        if (bus_grant) begin
          s_d.gack_out = 1'b0;
          s_d.gack_oe_n = 1'b0;
          s_d.st = mcs_pkg::st_first;
          s_d.ph = 1'b0;
          s_d.wcnt = s_q.wait_cfg;
          s_d.first_wait = 1'b1;
          s_d.fin = 1'b0;
          s_d.term = 1'b0;
          s_d.retry_seen = 1'b0;
          // R1 drive address, code, direction
          s_d.pin_code = s_q.code;
          s_d.dir = s_q.mode ? !s_q.wr : s_q.wr;
          // R2 early strobe at first rise
          s_d.ecs_n = 1'b0;
          // R12 address-valid at first rise
          s_d.adstb_n = s_q.mode;
          // R16 async read strobe at first rise
          s_d.ds_n = !(!s_q.mode && !s_q.sync_bus && !s_q.wr);
        end
      end
      mcs_pkg::st_first: begin
        if (!s_q.ph) begin
          s_d.ph = 1'b1;
          s_d.ecs_n = 1'b1;
          if (s_q.mode) begin
            // R2 address strobe at first fall
            s_d.adstb_n = 1'b0;
            // R4 R10 read data strobe at first fall
            if (!s_q.wr) begin
              s_d.ds_n = 1'b0;
            end
          end
          // R5 R14 write data from first fall
          s_d.data_oe_n = !s_q.wr;
          // R7 R15 async sample at first fall, skipped while waits pending
          async_sample = !s_q.sync_bus && s_q.wcnt == 2'h0;
        end else begin
          s_d.ph = 1'b0;
          // R12 address-valid dropped at second rise
          if (!s_q.mode) begin
            s_d.adstb_n = 1'b1;
          end
          // R24 programmed waits first
          if (s_q.wcnt != 2'h0) begin
            s_d.st = mcs_pkg::st_wait;
            // R17 async write strobe at first wait rise
            if (!s_q.mode && !s_q.sync_bus && s_q.wr) begin
              s_d.ds_n = 1'b0;
            end
          end else begin
            s_d.st = mcs_pkg::st_second;
          end
        end
        // R21 async retry from first fall on
        if (s_q.ph && retry_async_now) begin
          s_d.retry_seen = 1'b1;
        end
      end
      mcs_pkg::st_wait: begin
        if (!s_q.ph) begin
          s_d.ph = 1'b1;
          // R5 R10 big-endian write strobe at first wait fall
          if (s_q.mode && s_q.wr && s_q.first_wait) begin
            s_d.ds_n = 1'b0;
          end
          // R24 async acknowledge may come in last wait
          async_sample = !s_q.sync_bus && s_q.wcnt == 2'h1;
        end else begin
          s_d.ph = 1'b0;
          s_d.first_wait = 1'b0;
          s_d.wcnt = s_q.wcnt - 2'h1;
          if (s_q.wcnt == 2'h1) begin
            s_d.st = mcs_pkg::st_second;
          end
        end
        if (retry_async_now) begin
          s_d.retry_seen = 1'b1;
        end
      end
      mcs_pkg::st_second: begin
        if (!s_q.ph) begin
          s_d.ph = 1'b1;
          // R3 sync size acknowledge at second rise
          if (s_q.mode && s_q.sync_bus && size_acknowledge_pair_n == 2'h0) begin
            s_d.term = 1'b1;
          end
          // R8 sync termination in async mode
          if (s_q.mode && !s_q.sync_bus && !sync_termination_n) begin
            s_d.term = 1'b1;
          end
          // R21 sync retry sampled at second rise
          if ((s_q.retry_sync && !bus_retry_request_n) || retry_async_now) begin
            s_d.retry_seen = 1'b1;
          end
          // R9 R15 async acknowledge sampled earlier ends this state
          if (s_q.term || s_d.term || s_d.retry_seen) begin
            s_d.fin = s_q.mode || !s_q.sync_bus || s_d.retry_seen;
          end
          if (s_d.fin) begin
            // R6 R16 strobes dropped at final fall
            s_d.ds_n = 1'b1;
            if (s_q.mode) begin
              s_d.adstb_n = 1'b1;
            end
            // R4 data caught at final fall
            if (!s_q.wr) begin
              s_d.rdata = data_in;
            end
          end else begin
            // R7 R15 async sample at second fall
            async_sample = !s_q.sync_bus;
          end
        end else begin
          s_d.ph = 1'b0;
          // R20 retry wins; R13 R14 sync ready at end of second state
          if (!s_q.fin && !s_q.mode && s_q.sync_bus && !ready_input_n && !s_q.retry_seen) begin
            s_d.fin = 1'b1;
            if (!s_q.wr) begin
              s_d.rdata = data_in;
            end
          end
          if (s_d.fin) begin
            // R18 end cycle and release bus
            s_d.data_oe_n = 1'b1;
            s_d.ds_n = 1'b1;
            s_d.adstb_n = 1'b1;
            s_d.bus_req = 1'b0;
            s_d.gack_out = 1'b1;
            s_d.pin_code = `MCS_CODE_IDLE;
            s_d.st = s_q.retry_seen ? mcs_pkg::st_holdoff : mcs_pkg::st_release;
          end
        end
      end
      mcs_pkg::st_release: begin
        // R23 high half a bus clock, then float
        s_d.gack_oe_n = 1'b1;
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        s_d.st = mcs_pkg::st_idle;
      end
      mcs_pkg::st_holdoff: begin
        // R23 high half a bus clock, then float
        s_d.gack_oe_n = 1'b1;
        // R19 latched or immediate retry
        if (s_q.latched_retry_enable) begin
          s_d.retry_status = 1'b1;
          s_d.st = mcs_pkg::st_retry_wait;
        end else begin
          s_d.bus_req = 1'b1;
          s_d.st = mcs_pkg::st_request;
        end
      end
      mcs_pkg::st_retry_wait: begin
        // R19 wait for status clear and retry released
        if (!s_q.retry_status && bus_retry_request_n) begin
          s_d.bus_req = 1'b1;
          s_d.st = mcs_pkg::st_request;
        end
      end
      default: begin
        s_d.st = mcs_pkg::st_idle;
      end
    endcase

    // R9 R15 async acknowledge arms the final second state
    if (async_sample && async_term) begin
      s_d.term = 1'b1;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= mcs_pkg::st_idle;
      s_q.wait_cfg <= `MCS_RST_WAIT;
      s_q.sync_bus <= `MCS_RST_SYNC_BUS;
      s_q.retry_sync <= `MCS_RST_RETRY_SYNC;
      s_q.code <= `MCS_CODE_IDLE;
      s_q.pin_code <= `MCS_CODE_IDLE;
      s_q.gack_out <= 1'b1;
      s_q.gack_oe_n <= 1'b1;
      s_q.ecs_n <= 1'b1;
      s_q.adstb_n <= 1'b1;
      s_q.ds_n <= 1'b1;
      s_q.data_oe_n <= 1'b1;
      s_q.ack_s1 <= 2'h3;
      s_q.ack_s2 <= 2'h3;
      s_q.brt_s1 <= 1'b1;
      s_q.brt_s2 <= 1'b1;
      s_q.wait_q <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign readdata = s_q.readdata;
  assign waitrequest = s_q.wait_q;
  assign bus_request = s_q.bus_req;
  assign grant_acknowledge_out = s_q.gack_out;
  assign grant_acknowledge_oe_n = s_q.gack_oe_n;
  assign mem_address = s_q.addr;
  assign bus_status_code = s_q.pin_code;
  assign direction_strobe = s_q.dir;
  assign early_cycle_strobe_n = s_q.ecs_n;
  assign address_strobe_n = s_q.adstb_n;
  assign data_strobe_n = s_q.ds_n;
  assign data_out = s_q.wdata;
  assign data_oe_n = s_q.data_oe_n;

endmodule : master_memory_cycle_sequencer

`default_nettype wire

// ==== bench/mcs_props.sv ====
// Purpose: port assertions for the memory cycle sequencer
// Assumes: one clock, synchronous active-high reset
// Notes: attached by bind below
`timescale 1ns/1ps
`default_nettype none
module mcs_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic byte_order_pin_mode,
  input wire logic grant_acknowledge_out,
  input wire logic grant_acknowledge_oe_n,
  input wire logic [30:0] mem_address,
  input wire logic [2:0] bus_status_code,
  input wire logic direction_strobe,
  input wire logic early_cycle_strobe_n,
  input wire logic address_strobe_n,
  input wire logic data_strobe_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ----
  // memory cycle and register answer
  // ----
  property p_hold;
    bus_status_code != 3'h7 && $past(bus_status_code) != 3'h7
      |-> $stable(mem_address) && $stable(direction_strobe) && $stable(bus_status_code);
  endproperty
  a_hold: assert property (p_hold) else $error("cycle address or status moved");
  property p_ecs_owned;
    !early_cycle_strobe_n |-> !grant_acknowledge_oe_n && !grant_acknowledge_out && bus_status_code != 3'h7;
  endproperty
  a_ecs_owned: assert property (p_ecs_owned) else $error("cycle start without bus");
  property p_ecs_one;
    $fell(early_cycle_strobe_n) |=> early_cycle_strobe_n;
  endproperty
  a_ecs_one: assert property (p_ecs_one) else $error("early strobe too long");
  property p_be_as;
    byte_order_pin_mode && $fell(early_cycle_strobe_n) |-> address_strobe_n ##1 !address_strobe_n;
  endproperty
  a_be_as: assert property (p_be_as) else $error("address strobe not at first fall");
  property p_le_ads;
    !byte_order_pin_mode && $fell(early_cycle_strobe_n) |-> !address_strobe_n ##1 !address_strobe_n ##1 address_strobe_n;
  endproperty
  a_le_ads: assert property (p_le_ads) else $error("address valid timing off");
  property p_be_end;
    byte_order_pin_mode && $rose(address_strobe_n) |-> data_strobe_n;
  endproperty
  a_be_end: assert property (p_be_end) else $error("strobes not dropped together");
  property p_idle;
    grant_acknowledge_oe_n |-> data_strobe_n && early_cycle_strobe_n;
  endproperty
  a_idle: assert property (p_idle) else $error("strobe while bus released");
  property p_gack;
    $rose(grant_acknowledge_out) |=> $rose(grant_acknowledge_oe_n);
  endproperty
  a_gack: assert property (p_gack) else $error("grant ack not driven high before float");
  property p_answer;
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("register answer late");
endmodule : mcs_props
bind master_memory_cycle_sequencer mcs_props u_props (.clk, .rst, .read, .write, .waitrequest,
  .byte_order_pin_mode, .grant_acknowledge_out, .grant_acknowledge_oe_n, .mem_address,
  .bus_status_code, .direction_strobe, .early_cycle_strobe_n, .address_strobe_n, .data_strobe_n);
`default_nettype wire

// ==== bench/mem_partner.sv ====
// Purpose: memory and termination model for the sequencer
// Assumes: grant follows request one clock later
// Notes: released data bus shows the inverted word
`timescale 1ns/1ps
`default_nettype none
module mem_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_request,
  input wire logic grant_acknowledge_oe_n,
  input wire logic early_cycle_strobe_n,
  input wire logic data_oe_n,
  input wire logic [31:0] data_out,
  input wire logic [2:0] lat,
  input wire logic term,
  input wire logic arm,
  input wire logic keep,
  input wire logic [31:0] word,
  output logic bus_grant,
  output logic [31:0] data_in,
  output logic [1:0] size_acknowledge_pair_n,
  output logic sync_termination_n,
  output logic bus_retry_request_n,
  output logic [31:0] wr_seen
);
  logic [3:0] cnt_q;
  logic ack_q, armed_q, kept_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_grant <= 1'b0;
      cnt_q <= 4'h0;
      ack_q <= 1'b1;
      armed_q <= 1'b0;
      kept_q <= 1'b0;
      bus_retry_request_n <= 1'b1;
      wr_seen <= 32'h0;
    end else begin
      bus_grant <= bus_request;
      cnt_q <= grant_acknowledge_oe_n ? 4'h0 : (cnt_q == 4'hf ? cnt_q : cnt_q + 4'h1);
      ack_q <= !(!grant_acknowledge_oe_n && cnt_q >= {1'b0, lat});
      if (!data_oe_n) wr_seen <= data_out;
      if (arm) armed_q <= 1'b1;
      if (armed_q && !early_cycle_strobe_n) begin
        bus_retry_request_n <= 1'b0;
        armed_q <= 1'b0;
      end
      if (keep && !bus_retry_request_n) kept_q <= 1'b1;
      if (!bus_retry_request_n && !keep && grant_acknowledge_oe_n && (bus_request || kept_q)) begin
        bus_retry_request_n <= 1'b1;
        kept_q <= 1'b0;
      end
    end
  end
  assign sync_termination_n = term ? ack_q : 1'b1;
  assign size_acknowledge_pair_n = term ? 2'h3 : {2{ack_q}};
  assign data_in = (!grant_acknowledge_oe_n && data_oe_n) ? word : ~word;
endmodule : mem_partner
`default_nettype wire

// ==== bench/tb_top.sv ====
// Purpose: self-checking bench of the memory cycle sequencer
// Assumes: registers reached over Avalon-MM
// Notes: mode strap changes only across a reset
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic be; logic sync; logic term; logic wr; logic [1:0] wc; logic [2:0] code; logic [2:0] lat;
  } row_type;
  logic clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, byte_order_pin_mode = 1'b1;
  logic term = 1'b0, arm = 1'b0, keep = 1'b0;
  logic [2:0] lat = 3'h0;
  logic [4:0] address = 5'h00;
  logic [31:0] writedata = 32'h0, word = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata, data_out, data_in, wr_seen;
  logic waitrequest, bus_request, bus_grant, grant_acknowledge_out, grant_acknowledge_oe_n;
  logic direction_strobe, early_cycle_strobe_n, address_strobe_n, data_strobe_n, data_oe_n;
  logic sync_termination_n, bus_retry_request_n, dir_seen;
  logic [30:0] mem_address, addr_seen;
  logic [2:0] bus_status_code, code_seen;
  logic [1:0] size_acknowledge_pair_n;
  int err_count = 0, cmp_count = 0, len = 0, ds_cnt = 0, ecs_cnt = 0;
  // fields: be sync term wr wc[1:0] code[2:0] lat[2:0]
  logic [11:0] rows [15] = '{12'hc00, 12'hd08, 12'hc50, 12'hd98, 12'hce0, 12'hc2e, 12'h830, 12'h970,
    12'ha10, 12'h908, 12'h418, 12'h560, 12'h068, 12'h100, 12'h436};
  master_memory_cycle_sequencer dut (.clk, .rst, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .byte_order_pin_mode, .bus_request, .bus_grant, .grant_acknowledge_out,
    .grant_acknowledge_oe_n, .mem_address, .bus_status_code, .direction_strobe, .early_cycle_strobe_n,
    .address_strobe_n, .data_strobe_n, .data_out, .data_oe_n, .data_in, .size_acknowledge_pair_n,
    .sync_termination_n, .bus_retry_request_n);
  mem_partner u_mem (.clk, .rst, .bus_request, .grant_acknowledge_oe_n, .early_cycle_strobe_n,
    .data_oe_n, .data_out, .lat, .term, .arm, .keep, .word, .bus_grant, .data_in,
    .size_acknowledge_pair_n, .sync_termination_n, .bus_retry_request_n, .wr_seen);
  initial forever #20 clk = ~clk;
  // ----
  // monitors and helpers
  // ----
  always @(posedge clk) begin
    if (!grant_acknowledge_oe_n) len <= len + 1;
    if (!data_strobe_n) ds_cnt <= ds_cnt + 1;
    if (!early_cycle_strobe_n) begin
      ecs_cnt <= ecs_cnt + 1;
      code_seen <= bus_status_code;
      dir_seen <= direction_strobe;
      addr_seen <= mem_address;
    end
  end
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic av(input logic rd, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    address <= a;
    writedata <= d;
    read <= rd;
    write <= !rd;
    @(posedge clk iff waitrequest === 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : av
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] x;
    av(1'b0, a, d, x);
  endtask : wr
  task automatic wait_done;
    logic [31:0] s;
    s = 32'h1;
    for (int k = 0; k < 60 && s[0] !== 1'b0; k++) av(1'b1, 5'h14, 32'h0, s);
    chk(s[0], 32'h0);
  endtask : wait_done
  task automatic do_reset(input logic m);
    logic [31:0] v;
    byte_order_pin_mode <= m;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    av(1'b1, 5'h14, 32'h0, v);
    chk(v, {28'h0, m, 3'h0});
    av(1'b1, 5'h04, 32'h0, v);
    chk(v, 32'h14);
    av(1'b1, 5'h18, 32'h0, v);
    chk(v, 32'h0);
  endtask : do_reset
  task automatic run(input row_type r, input int i);
    logic [31:0] v, a;
    int l0, d0, e0;
    a = 32'h1000 | (i << 4);
    lat <= r.lat;
    term <= r.term;
    word <= 32'h5a000000 | i;
    wr(5'h04, {27'h0, 1'b1, 1'b0, r.sync, r.wc});
    wr(5'h08, a);
    wr(5'h0c, ~(32'h5a000000 | i));
    l0 = len;
    d0 = ds_cnt;
    e0 = ecs_cnt;
    wr(5'h00, {27'h0, r.code, r.wr, 1'b1});
    wait_done;
    chk(code_seen, r.code);
    chk(addr_seen, a >> 1);
    chk(dir_seen, r.be ? !r.wr : r.wr);
    chk(ds_cnt != d0, (r.be || !r.sync) && (!r.wr || r.wc != 2'h0));
    chk(ecs_cnt - e0, 1);
    if (r.wr) chk(wr_seen, ~(32'h5a000000 | i));
    else begin
      av(1'b1, 5'h10, 32'h0, v);
      chk(v, 32'h5a000000 | i);
    end
    if (r.be && r.sync && r.lat == 3'h0) chk(len - l0, 5 + 2 * r.wc);
    if (r.lat != 3'h0) chk(len - l0 > 5, 1);
  endtask : run
  // ----
  // main sequence
  // ----
  initial begin
    logic [31:0] v;
    int e0;
    do_reset(1'b1);
    for (int i = 0; i < 15; i++) begin
      if (rows[i][11] !== byte_order_pin_mode) do_reset(rows[i][11]);
      run(row_type'(rows[i]), i);
    end
    lat <= 3'h0;
    term <= 1'b0;
    wr(5'h04, 32'h14);
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
    e0 = ecs_cnt;
    wr(5'h00, 32'h9);
    wait_done;
    chk(ecs_cnt - e0, 2);
    av(1'b1, 5'h14, 32'h0, v);
    chk(v[2:0], 3'h2);
    wr(5'h14, 32'h2);
    wr(5'h04, 32'h1c);
    arm <= 1'b1;
    keep <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
    e0 = ecs_cnt;
    wr(5'h00, 32'h9);
    repeat (40) @(posedge clk);
    av(1'b1, 5'h14, 32'h0, v);
    chk(v[2:0], 3'h5);
    keep <= 1'b0;
    repeat (40) @(posedge clk);
    chk(ecs_cnt - e0, 1);
    wr(5'h14, 32'h4);
    wait_done;
    chk(ecs_cnt - e0, 2);
    av(1'b1, 5'h10, 32'h0, v);
    chk(v, word);
    wr(5'h04, 32'h0);
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
    e0 = ecs_cnt;
    wr(5'h00, 32'h9);
    wait_done;
    chk(ecs_cnt - e0, 2);
    close_out;
  end
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    close_out;
  end
endmodule : tb_top
`default_nettype wire
